// [fracn_divider_tuning_control.sv]
// reference divider, fractional modulator and tuning registers
// Functional notes
// - phase offset made by dc pump current
// - bit 21 up offset, bit 22 down
// - offset magnitude 7 bits, 5 uA steps
// - integer mode comparator runs without offset
// - output divider even ratio 2..62
// - doubler enabled by oscillator reg 3 bit 0
// - integer mode: modulator off, bypassed
// - fractional mode: modulator on, in circuit
// - integer mode ratio 16..2^19-1, modulator off
// - oscillator registers written through reg 0x05
// - reference divided by reg 0x02 ratio
// - fraction of 2^24 added to integer
// - fractional integer ratio 20..524284
// - output factor half, one or divider
// - step count in 0x0c gives exact frequency
// - accumulator keeps full 24-bit modulus
// - pump currents from reg 0x09 fields
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fracn_divider_tuning_control
    import fracn_tune_pkg::*;
#(
    parameter int REF_W = 14,
    parameter int STEP_W = 14
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic PD_TICK,
    output logic [19:0] DIV_RATIO,
    output logic FRAC_MODE,
    output pump_t PUMP,
    output logic OSC_WR,
    output logic [3:0] OSC_ADDR,
    output logic [8:0] OSC_DATA,
    output logic [5:0] OUT_DIV,
    output logic OUT_DOUBLE,
    output logic RATIO_OK
);
    initial begin
        if (REF_W < 1 || REF_W > 16 || STEP_W < 1 || STEP_W > 16) begin
            $error("unsupported counter width");
        end
    end

    logic [REF_W-1:0] ref_div;
    logic [18:0] int_div;
    logic [23:0] frac;
    logic mod_en;
    logic mod_byp;
    logic [22:0] pump_reg;
    logic [STEP_W-1:0] step;
    logic [REF_W-1:0] ref_cnt;
    logic [STEP_W-1:0] step_cnt;
    logic [23:0] acc;
    logic [5:0] osc_div;
    logic osc_dbl;

    // address decode
    wire wr_ref = WR && (ADDR == OFS_REF_DIV);
    wire wr_int = WR && (ADDR == OFS_INT_DIV);
    wire wr_frac = WR && (ADDR == OFS_FRAC);
    wire wr_osc = WR && (ADDR == OFS_OSC_PORT);
    wire wr_mod = WR && (ADDR == OFS_MOD_CTRL);
    wire wr_pump = WR && (ADDR == OFS_PUMP);
    wire wr_step = WR && (ADDR == OFS_STEP);

    // mode select; the mixed settings fall back to integer
    wire frac_mode = mod_en && !mod_byp;
    wire exact = frac_mode && (step != '0);

    // reference divider; a zero ratio is taken as one
    // compared with >= so a ratio lowered mid-count still wraps at once
    // instead of running the counter round its whole range
    wire [REF_W-1:0] ref_last = (ref_div == '0) ? '0 : ref_div - 1'b1;
    wire pd_tick = (ref_cnt >= ref_last);

    // modulator sum, carry in bit 24
    // first-order only: cheap, but its pattern is plainer than a
    // higher-order shaper would give
    wire [24:0] sum = {1'b0, acc} + {1'b0, frac};
    wire carry = frac_mode && sum[24];
    wire step_wrap = exact && (step_cnt == step - 1'b1);
    wire [23:0] next_acc = !frac_mode ? 24'h000000 : (step_wrap ? 24'h000000 : sum[23:0]);

    // ratio range check depends on the mode
    wire ratio_ok = frac_mode ? (int_div >= FRAC_MODE_MIN && int_div <= FRAC_MODE_MAX)
                              : (int_div >= INT_MODE_MIN);

    // indirect oscillator write fields
    wire [3:0] osc_a = WDATA[OSC_ADDR_LSB +: 4];
    wire [8:0] osc_d = WDATA[OSC_DATA_LSB +: 9];
    // only 1 or an even ratio up to 62 is taken; others are ignored
    wire osc_div_ok = (osc_d[5:0] == 6'h01) ||
                      (!osc_d[0] && osc_d[5:0] != 6'h00 && osc_d[5:0] <= OUT_DIV_MAX);

    // read mux; unmapped offsets read zero
    wire [31:0] status = {acc, 5'h00, exact, ratio_ok, frac_mode};
    wire [31:0] rd_mux =
        (ADDR == OFS_REF_DIV) ? 32'(ref_div) :
        (ADDR == OFS_INT_DIV) ? 32'(int_div) :
        (ADDR == OFS_FRAC) ? 32'(frac) :
        (ADDR == OFS_MOD_CTRL) ? 32'({mod_en, 3'h0, mod_byp, 7'h00}) :
        (ADDR == OFS_PUMP) ? 32'(pump_reg) :
        (ADDR == OFS_STEP) ? 32'(step) :
        (ADDR == OFS_STATUS) ? status : 32'h00000000;

    // pump outputs; offset is a dc current, neither divided edge is delayed
    // offsets are gated by the mode so a stale setting cannot skew
    // the comparator once the loop drops back to integer
    pump_t next_pump;
    always_comb begin
        next_pump.down_pump_current = pump_reg[DN_LSB +: 7];
        next_pump.up_pump_current = pump_reg[UP_LSB +: 7];
        next_pump.offset_mag = frac_mode ? pump_reg[OFF_MAG_LSB +: 7] : 7'h00;
        next_pump.offset_up = frac_mode && pump_reg[OFF_UP_BIT];
        next_pump.offset_down = frac_mode && pump_reg[OFF_DN_BIT];
    end

    // software registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ref_div <= REF_W'(RST_REF_DIV);
            int_div <= RST_INT_DIV;
            frac <= 24'h000000;
            mod_en <= 1'b0;
            mod_byp <= 1'b1;
            pump_reg <= 23'h000000;
            step <= '0;
        end else begin
            if (wr_ref) ref_div <= WDATA[REF_W-1:0];
            if (wr_int) int_div <= WDATA[18:0];
            if (wr_frac) frac <= WDATA[23:0];
            if (wr_mod) begin
                mod_en <= WDATA[MOD_EN_BIT];
                mod_byp <= WDATA[MOD_BYP_BIT];
            end
            if (wr_pump) pump_reg <= WDATA[22:0];
            if (wr_step) step <= WDATA[STEP_W-1:0];
        end
    end

    // oscillator subsystem registers, reached only through the port word
    // the port word is also passed on, so the subsystem sees every write
    always_ff @(posedge CLK) begin
        if (SRST) begin
            osc_div <= RST_OUT_DIV;
            osc_dbl <= 1'b0;
            OSC_WR <= 1'b0;
            OSC_ADDR <= 4'h0;
            OSC_DATA <= 9'h000;
        end else begin
            OSC_WR <= wr_osc;
            if (wr_osc) begin
                OSC_ADDR <= osc_a;
                OSC_DATA <= osc_d;
            end
            if (wr_osc && osc_a == OSC_REG_DIV && osc_div_ok) osc_div <= osc_d[5:0];
            if (wr_osc && osc_a == OSC_REG_DBL) osc_dbl <= osc_d[0];
        end
    end

    // comparison timing and modulator; the modulus is never shortened,
    // exactness comes from restarting the phase every step count
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ref_cnt <= '0;
            step_cnt <= '0;
            acc <= 24'h000000;
            DIV_RATIO <= 20'(RST_INT_DIV);
        end else begin
            ref_cnt <= pd_tick ? '0 : ref_cnt + 1'b1;
            if (pd_tick) begin
                acc <= next_acc;
                step_cnt <= (!exact || step_wrap) ? '0 : step_cnt + 1'b1;
                DIV_RATIO <= {1'b0, int_div} + {19'h00000, carry};
            end
        end
    end

    // registered outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 32'h00000000;
            PD_TICK <= 1'b0;
            FRAC_MODE <= 1'b0;
            PUMP <= '0;
            RATIO_OK <= 1'b0;
        end else begin
            RDATA <= RD ? rd_mux : 32'h00000000;
            PD_TICK <= pd_tick;
            FRAC_MODE <= frac_mode;
            PUMP <= next_pump;
            RATIO_OK <= ratio_ok;
        end
    end

    // output factor: half with the doubler, else the divider (1 = fundamental)
    assign OUT_DIV = osc_div;
    assign OUT_DOUBLE = osc_dbl;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    // checks below look one clock after the cause, as every output is
    // registered; reset disables them so no attempt spans its release

    sequence s_osc_dbl_write;
        WR && ADDR == OFS_OSC_PORT && WDATA[3:0] == OSC_REG_DBL;
    endsequence

    // oscillator port word on its way to the subsystem
    sequence s_osc_write;
        WR && ADDR == OFS_OSC_PORT;
    endsequence

    // divider write that carries a legal ratio
    sequence s_osc_div_write;
        WR && ADDR == OFS_OSC_PORT && WDATA[3:0] == OSC_REG_DIV && osc_div_ok;
    endsequence

    a_int_no_offset: assert property (!frac_mode |=> PUMP.offset_mag == 7'h00
        && !PUMP.offset_up && !PUMP.offset_down)
        else $error("offset present in integer mode");
    a_offset_dir: assert property (frac_mode && !wr_pump |=> PUMP.offset_down
        == $past(pump_reg[OFF_DN_BIT]) && PUMP.offset_up == $past(pump_reg[OFF_UP_BIT]))
        else $error("offset direction wrong");
    a_int_ratio_plain: assert property (pd_tick && !frac_mode |=>
        DIV_RATIO == {1'b0, $past(int_div)} && acc == 24'h000000)
        else $error("integer mode ratio altered");
    a_carry_extend: assert property (pd_tick && frac_mode && sum[24] |=>
        DIV_RATIO == {1'b0, $past(int_div)} + 20'h00001)
        else $error("carry did not extend ratio");
    a_ref_period: assert property (pd_tick && ref_div == 14'h0003 && !wr_ref |=>
        !pd_tick ##1 !pd_tick ##1 pd_tick)
        else $error("reference divide wrong");
    a_exact_restart: assert property (pd_tick && step_wrap |=> acc == 24'h000000
        && step_cnt == '0)
        else $error("exact step restart missed");
    a_doubler_write: assert property (s_osc_dbl_write |=> OUT_DOUBLE == $past(WDATA[4])
        && OSC_ADDR == OSC_REG_DBL)
        else $error("doubler write lost");
    a_div_even: assert property (OUT_DIV == 6'h01 || (!OUT_DIV[0] && OUT_DIV <= OUT_DIV_MAX
        && OUT_DIV != 6'h00))
        else $error("output divider illegal");
    a_frac_range: assert property (frac_mode && int_div > FRAC_MODE_MAX |=> !RATIO_OK)
        else $error("range flag wrong");

    // every port word leaves as one pulse with its address and data
    a_osc_forward: assert property (s_osc_write |=> OSC_WR
        && OSC_ADDR == $past(osc_a) && OSC_DATA == $past(osc_d))
        else $error("oscillator word not forwarded");
    // no stray pulse toward the subsystem
    a_osc_quiet: assert property (!wr_osc |=> !OSC_WR)
        else $error("spurious oscillator write");
    // a legal divider ratio lands the next cycle
    a_div_write: assert property (s_osc_div_write |=> OUT_DIV == $past(osc_d[5:0]))
        else $error("divider write lost");
    // magnitude follows the register while fractional
    a_offset_mag: assert property (frac_mode && !wr_pump |=> PUMP.offset_mag
        == $past(pump_reg[OFF_MAG_LSB +: 7]))
        else $error("offset magnitude wrong");
    // gains pass whatever the mode
    a_pump_gains: assert property (1'b1 |=>
        PUMP.down_pump_current == $past(pump_reg[DN_LSB +: 7])
        && PUMP.up_pump_current == $past(pump_reg[UP_LSB +: 7]))
        else $error("pump gain wrong");
    // comparison tick leaves one clock after the divider wraps
    a_tick_out: assert property (1'b1 |=> PD_TICK == $past(pd_tick))
        else $error("tick output misplaced");
    // mode flag follows the two control bits
    a_mode_flag: assert property (1'b1 |=> FRAC_MODE == $past(mod_en && !mod_byp))
        else $error("mode flag wrong");
    // a legal integer ratio is flagged good
    a_int_range: assert property (!frac_mode && int_div >= INT_MODE_MIN |=> RATIO_OK)
        else $error("integer range flag wrong");
    // too small a ratio is flagged in fractional mode
    a_frac_low: assert property (frac_mode && int_div < FRAC_MODE_MIN |=> !RATIO_OK)
        else $error("low ratio not flagged");
    // read data stand only in the cycle after the strobe
    a_read_idle: assert property (!RD |=> RDATA == 32'h00000000)
        else $error("read data outside read cycle");
endmodule : fracn_divider_tuning_control
`default_nettype wire

// [fracn_tune_pkg.sv]
// shared constants and types for the fractional-n tuning control
package fracn_tune_pkg;
    // register word offsets
    localparam logic [7:0] OFS_REF_DIV = 8'h02;
    localparam logic [7:0] OFS_INT_DIV = 8'h03;
    localparam logic [7:0] OFS_FRAC = 8'h04;
    localparam logic [7:0] OFS_OSC_PORT = 8'h05;
    localparam logic [7:0] OFS_MOD_CTRL = 8'h06;
    localparam logic [7:0] OFS_PUMP = 8'h09;
    localparam logic [7:0] OFS_STEP = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // field positions
    localparam int MOD_EN_BIT = 11;
    localparam int MOD_BYP_BIT = 7;
    localparam int DN_LSB = 0;
    localparam int UP_LSB = 7;
    localparam int OFF_MAG_LSB = 14;
    localparam int OFF_UP_BIT = 21;
    localparam int OFF_DN_BIT = 22;
    localparam int OSC_ADDR_LSB = 0;
    localparam int OSC_DATA_LSB = 4;
    // oscillator subsystem register numbers
    localparam logic [3:0] OSC_REG_DIV = 4'h2;
    localparam logic [3:0] OSC_REG_DBL = 4'h3;
    // reset values
    localparam logic [13:0] RST_REF_DIV = 14'h0001;
    localparam logic [18:0] RST_INT_DIV = 19'h00014;
    localparam logic [5:0] RST_OUT_DIV = 6'h01;
    // divide ratio limits
    localparam logic [18:0] INT_MODE_MIN = 19'h00010;
    localparam logic [18:0] FRAC_MODE_MIN = 19'h00014;
    localparam logic [18:0] FRAC_MODE_MAX = 19'h7fffc;
    localparam logic [5:0] OUT_DIV_MAX = 6'h3e;
    // charge pump settings, 5 uA per offset code
    typedef struct packed {
        logic [6:0] up_pump_current;
        logic [6:0] down_pump_current;
        logic offset_up;
        logic offset_down;
        logic [6:0] offset_mag;
    } pump_t;
endpackage : fracn_tune_pkg

// [tb_top.sv]
// self-checking bench for the fractional-n tuning control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top
    import fracn_tune_pkg::*;
;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic [31:0] RDATA;
    logic PD_TICK, FRAC_MODE, OSC_WR, OUT_DOUBLE, RATIO_OK;
    logic [19:0] DIV_RATIO;
    pump_t PUMP;
    logic [3:0] OSC_ADDR;
    logic [8:0] OSC_DATA;
    logic [5:0] OUT_DIV;
    int errors = 0, checks_done = 0, seed = 66, osc_n = 0, ticks = 0, t0, n0;
    logic rd_seen = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] q_exp, v;
    logic [19:0] d0, d1, d2;

    fracn_divider_tuning_control dut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .PD_TICK(PD_TICK), .DIV_RATIO(DIV_RATIO),
        .FRAC_MODE(FRAC_MODE), .PUMP(PUMP), .OSC_WR(OSC_WR), .OSC_ADDR(OSC_ADDR),
        .OSC_DATA(OSC_DATA), .OUT_DIV(OUT_DIV), .OUT_DOUBLE(OUT_DOUBLE), .RATIO_OK(RATIO_OK));

    // 25 mhz clock
    initial forever #20 CLK = ~CLK;

    // read data stands only in the cycle after the strobe, so look at mid-cycle
    always @(posedge CLK) begin
        rd_seen <= RD;
        osc_n <= osc_n + OSC_WR;
        ticks <= ticks + PD_TICK;
    end
    always @(negedge CLK) begin
        if (rd_seen) begin
            q_exp = exp_q.pop_front();
            `CHK(RDATA, q_exp)
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK);
        exp_q.push_back(e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
    endtask : rd

    // registered outputs need a couple of edges to follow a write
    task automatic settle;
        repeat (3) @(negedge CLK);
    endtask : settle

    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // watchdog, the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge CLK);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge CLK);
        SRST <= 1'b0;
        rd(OFS_REF_DIV, 32'h1);
        rd(OFS_INT_DIV, 32'h14);
        rd(OFS_FRAC, 32'h0);
        rd(OFS_PUMP, 32'h0);
        rd(OFS_STEP, 32'h0);
        rd(OFS_OSC_PORT, 32'h0);
        rd(OFS_MOD_CTRL, 32'h80);
        settle();
        `CHK(DIV_RATIO, 20'h00014)
        `CHK(OUT_DIV, 6'h01)
        `CHK(FRAC_MODE, 1'b0)
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            v = 32'h14 + ($random(seed) & 32'hffff);
            wr(OFS_INT_DIV, v);
            rd(OFS_INT_DIV, v);
            v = $random(seed);
            wr(OFS_FRAC, v);
            rd(OFS_FRAC, v & 32'hffffff);
            wr(8'h01, v);
            rd(8'h01, 32'h0);
        end
        $display("test register readback done");
        wr(OFS_PUMP, 32'h00535964);
        rd(OFS_PUMP, 32'h00535964);
        settle();
        `CHK(PUMP, 23'h32c800)
        wr(OFS_MOD_CTRL, 32'h800);
        settle();
        `CHK(FRAC_MODE, 1'b1)
        `CHK(PUMP, 23'h32c8cd)
        wr(OFS_PUMP, 32'h00335964);
        settle();
        `CHK(PUMP, 23'h32c94d)
        wr(OFS_PUMP, 32'h00499932);
        settle();
        `CHK(PUMP, 23'h3264a6)
        wr(OFS_PUMP, 32'h00003964);
        wr(OFS_MOD_CTRL, 32'h880);
        settle();
        `CHK(FRAC_MODE, 1'b0)
        $display("test pump offset done");
        wr(OFS_MOD_CTRL, 32'h800);
        wr(OFS_INT_DIV, 32'h10);
        settle();
        `CHK(RATIO_OK, 1'b0)
        wr(OFS_MOD_CTRL, 32'h80);
        settle();
        `CHK(RATIO_OK, 1'b1)
        wr(OFS_MOD_CTRL, 32'h800);
        wr(OFS_INT_DIV, 32'h14);
        wr(OFS_FRAC, 32'h800000);
        settle();
        d0 = DIV_RATIO;
        @(negedge CLK);
        d1 = DIV_RATIO;
        @(negedge CLK);
        d2 = DIV_RATIO;
        `CHK(d0 + d1, 20'd41)
        `CHK(d1 + d2, 20'd41)
        // quarter steps restarted every two ticks never carry
        wr(OFS_STEP, 32'h2);
        wr(OFS_FRAC, 32'h400000);
        repeat (6) @(negedge CLK);
        repeat (8) begin
            @(negedge CLK);
            `CHK(DIV_RATIO, 20'h00014)
        end
        wr(OFS_STEP, 32'h0);
        $display("test modulator done");
        wr(OFS_REF_DIV, 32'h3);
        settle();
        t0 = ticks;
        repeat (30) @(negedge CLK);
        `CHK(ticks - t0, 10)
        n0 = osc_n;
        wr(OFS_OSC_PORT, 32'h42);
        settle();
        `CHK(OUT_DIV, 6'h04)
        `CHK(OSC_ADDR, 4'h2)
        `CHK(OSC_DATA, 9'h004)
        wr(OFS_OSC_PORT, 32'h52);
        wr(OFS_OSC_PORT, 32'h13);
        settle();
        `CHK(OUT_DIV, 6'h04)
        `CHK(OUT_DOUBLE, 1'b1)
        `CHK(osc_n - n0, 3)
        $display("test oscillator port done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
